//--- core/dram_init_pkg.sv
// Constants, commands and mode register layout shared by both ends of the init link.
// Assumes one 100 MHz clock drives the controller, the device model and the link between them.
package dram_init_pkg;

  localparam int MODE_REGS = 7;
  localparam int ADDR_W = 18;
  localparam int SEL_W = 3;
  localparam int CNT_W = 32;

  // Commands as seen on the link while clock enable is high.
  typedef enum logic [2:0] {
    CMD_DESELECT,
    CMD_MODE_SET,
    CMD_LONG_CAL,
    CMD_REFRESH,
    CMD_ACTIVE
  } cmd_t;

  // Mode register select codes; the controller sets the programming order.
  localparam logic [2:0] SEL_ZERO = 3'h0;
  localparam logic [2:0] SEL_ONE = 3'h1;
  localparam logic [2:0] SEL_TWO = 3'h2;
  localparam logic [2:0] SEL_THREE = 3'h3;
  localparam logic [2:0] SEL_FOUR = 3'h4;
  localparam logic [2:0] SEL_FIVE = 3'h5;
  localparam logic [2:0] SEL_SIX = 3'h6;
  localparam logic [2:0] SEL_UNUSED = 3'h7;

  // Field positions used by the dependency check.
  localparam int LOCK_ENABLE_BIT = 0;
  localparam int LOCK_RESET_BIT = 8;

  // Default wait counts in clock cycles at 100 MHz.
  localparam int CLK_PERIOD_NS = 10;
  localparam int CKE_SETUP_NS = 10;
  localparam int CKE_SETUP_CYC = (CKE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] DEF_RESET_PULSE = 32'h0000_0014;
  localparam logic [CNT_W-1:0] DEF_POST_RESET = 32'h0000_C350;
  localparam logic [CNT_W-1:0] DEF_EXIT = 32'h0000_0020;
  localparam logic [CNT_W-1:0] DEF_MODE_SET = 32'h0000_0008;
  localparam logic [CNT_W-1:0] DEF_MODE_UPDATE = 32'h0000_0018;
  localparam logic [CNT_W-1:0] DEF_LOCK = 32'h0000_0300;
  localparam logic [CNT_W-1:0] DEF_CAL = 32'h0000_0400;
  localparam logic [CNT_W-1:0] DEF_IDLE_LIMIT = 32'h05B8_D800;

endpackage

//--- core/dram_init_if.sv
// Link between the init controller and the device end: command, address and control pins.
// Assumes both ends run on the same sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface dram_init_if;
  import dram_init_pkg::*;
  logic resetPinN;
  logic clkEnable;
  logic chipSelN;
  cmd_t cmd;
  logic [SEL_W-1:0] regSel;
  logic [ADDR_W-1:0] addr;
  logic devReady;

  modport ctrl (output resetPinN, output clkEnable, output chipSelN, output cmd,
    output regSel, output addr, input devReady);
  modport dev (input resetPinN, input clkEnable, input chipSelN, input cmd,
    input regSel, input addr, output devReady);
endinterface
`default_nettype wire

//--- core/dram_init_ctrl.sv
// Controller end: drives reset, clock enable and the power-up and warm reset command sequence.
// Assumes the device end shares sys_clk and answers on the same interface.
`timescale 1ns/100ps
`default_nettype none
module dram_init_ctrl
  import dram_init_pkg::*;
#(
  parameter logic [CNT_W-1:0] RESET_PULSE = DEF_RESET_PULSE,
  parameter logic [CNT_W-1:0] POST_RESET = DEF_POST_RESET,
  parameter logic [CNT_W-1:0] EXIT_WAIT = DEF_EXIT,
  parameter logic [CNT_W-1:0] MODE_SET_WAIT = DEF_MODE_SET,
  parameter logic [CNT_W-1:0] MODE_UPDATE_WAIT = DEF_MODE_UPDATE,
  parameter logic [CNT_W-1:0] LOCK_WAIT = DEF_LOCK,
  parameter logic [CNT_W-1:0] CAL_WAIT = DEF_CAL,
  parameter logic [CNT_W-1:0] IDLE_LIMIT = DEF_IDLE_LIMIT
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic startReq,
  input wire logic supplyChanged,
  input wire logic [ADDR_W-1:0] modeValue [MODE_REGS],
  output logic initDone,
  output logic keepAlive,
  dram_init_if.ctrl link
);

  typedef enum {
    S_IDLE, S_RESET, S_CKE_LOW, S_POST, S_EXIT, S_LOAD, S_MSWAIT, S_LOAD0, S_MODWAIT,
    S_CAL, S_LOCKWAIT, S_READY
  } state_t;

  state_t state_q;
  logic [CNT_W-1:0] waitQ;
  logic [CNT_W-1:0] idleQ;
  logic [2:0] stepQ;

  // Order of the first six loads; register zero comes last.
  function automatic logic [2:0] orderSel(input logic [2:0] step);
    unique case (step)
      3'h0: orderSel = SEL_THREE;
      3'h1: orderSel = SEL_SIX;
      3'h2: orderSel = SEL_FIVE;
      3'h3: orderSel = SEL_FOUR;
      3'h4: orderSel = SEL_TWO;
      default: orderSel = SEL_ONE;
    endcase
  endfunction

  // Sequencer; the set, update and calibration waits load one less, as the cycle spent on zero restores the full count.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= S_IDLE;
      waitQ <= '0;
      stepQ <= '0;
      link.resetPinN <= 1'b0;
      link.clkEnable <= 1'b0;
      link.chipSelN <= 1'b1;
      link.cmd <= CMD_DESELECT;
      link.regSel <= SEL_ZERO;
      link.addr <= '0;
      initDone <= 1'b0;
    end else begin
      link.cmd <= CMD_DESELECT;
      link.chipSelN <= 1'b1;
      if (waitQ != '0) begin
        waitQ <= waitQ - 1'b1;
      end
      unique case (state_q)
        S_IDLE: begin
          if (startReq || supplyChanged) begin
            state_q <= S_CKE_LOW;
            link.clkEnable <= 1'b0;
            initDone <= 1'b0;
            waitQ <= CNT_W'(CKE_SETUP_CYC);
          end
        end
        S_CKE_LOW: begin
          if (waitQ == '0) begin
            link.resetPinN <= 1'b0;
            waitQ <= RESET_PULSE;
            state_q <= S_RESET;
          end
        end
        S_RESET: begin
          if (waitQ == '0) begin
            link.resetPinN <= 1'b1;
            waitQ <= POST_RESET;
            state_q <= S_POST;
          end
        end
        S_POST: begin
          if (waitQ == '0) begin
            link.clkEnable <= 1'b1;
            waitQ <= EXIT_WAIT;
            stepQ <= '0;
            state_q <= S_EXIT;
          end
        end
        S_EXIT, S_MSWAIT: begin
          if (waitQ == '0) begin
            state_q <= (stepQ == 3'(MODE_REGS - 1)) ? S_LOAD0 : S_LOAD;
          end
        end
        S_LOAD: begin
          link.cmd <= CMD_MODE_SET;
          link.chipSelN <= 1'b0;
          link.regSel <= orderSel(stepQ);
          link.addr <= modeValue[orderSel(stepQ)];
          stepQ <= stepQ + 1'b1;
          waitQ <= MODE_SET_WAIT - 1'b1;
          state_q <= S_MSWAIT;
        end
        S_LOAD0: begin
          link.cmd <= CMD_MODE_SET;
          link.chipSelN <= 1'b0;
          link.regSel <= SEL_ZERO;
          link.addr <= modeValue[SEL_ZERO];
          waitQ <= MODE_UPDATE_WAIT - 1'b1;
          state_q <= S_MODWAIT;
        end
        S_MODWAIT: begin
          if (waitQ == '0) begin
            state_q <= S_CAL;
          end
        end
        S_CAL: begin
          link.cmd <= CMD_LONG_CAL;
          link.chipSelN <= 1'b0;
          waitQ <= ((LOCK_WAIT > CAL_WAIT) ? LOCK_WAIT : CAL_WAIT) - 1'b1;
          state_q <= S_LOCKWAIT;
        end
        // Done needs both our own count and the device's word, since the device starts its
        // timers a cycle later. A device that never reports ready holds the sequence here.
        S_LOCKWAIT: begin
          if (waitQ == '0 && link.devReady) begin
            initDone <= 1'b1;
            state_q <= S_READY;
          end
        end
        S_READY: begin
          if (startReq || supplyChanged) begin
            initDone <= 1'b0;
            link.clkEnable <= 1'b0;
            waitQ <= CNT_W'(CKE_SETUP_CYC);
            state_q <= S_CKE_LOW;
          end else if (idleQ >= IDLE_LIMIT - 1'b1) begin
            link.cmd <= CMD_REFRESH;
            link.chipSelN <= 1'b0;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Idle keep-alive timer; restarts and pulses keepAlive every IDLE_LIMIT cycles in the ready state.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      idleQ <= '0;
      keepAlive <= 1'b0;
    end else if (state_q != S_READY || idleQ >= IDLE_LIMIT - 1'b1) begin
      idleQ <= '0;
      keepAlive <= (state_q == S_READY);
    end else begin
      idleQ <= idleQ + 1'b1;
      keepAlive <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- core/dram_init_dev.sv
// Device end: holds seven mode registers and reports readiness after lock and calibration.
// Assumes the controller keeps command spacing; set-to-set spacing violations are flagged, not corrected.
`timescale 1ns/100ps
`default_nettype none
module dram_init_dev
  import dram_init_pkg::*;
#(
  parameter logic [CNT_W-1:0] LOCK_WAIT = DEF_LOCK,
  parameter logic [CNT_W-1:0] CAL_WAIT = DEF_CAL,
  parameter logic [CNT_W-1:0] MODE_SET_WAIT = DEF_MODE_SET
) (
  input wire logic sys_clk,
  input wire logic resetn,
  dram_init_if.dev link,
  output logic [ADDR_W-1:0] modeReg [MODE_REGS],
  output logic [15:0] refreshCount,
  output logic spacingErr
);

  logic [CNT_W-1:0] lockQ;
  logic [CNT_W-1:0] calQ;
  logic [CNT_W-1:0] gapQ;
  logic calRun_q;
  logic ready_q;
  logic issued;

  assign issued = link.clkEnable && !link.chipSelN && link.resetPinN;

  // Mode registers change only on a set command or system reset; a reset pin low leaves them alone.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < MODE_REGS; i++) begin
        modeReg[i] <= '0;
      end
    end else if (issued && link.cmd == CMD_MODE_SET && link.regSel != SEL_UNUSED) begin
      modeReg[link.regSel] <= link.addr;
    end
  end

  // Lock and calibration timers; a reset pin low clears them, not the refresh count.
  always_ff @(posedge sys_clk) begin
    if (!resetn || !link.resetPinN) begin
      lockQ <= '0;
      calQ <= '0;
      calRun_q <= 1'b0;
      ready_q <= 1'b0;
      gapQ <= '0;
      spacingErr <= 1'b0;
    end else begin
      gapQ <= (gapQ != '0) ? gapQ - 1'b1 : gapQ;
      if (issued && link.cmd == CMD_MODE_SET) begin
        spacingErr <= spacingErr || (gapQ != '0);
        gapQ <= MODE_SET_WAIT - 1'b1;
        if (link.regSel == SEL_ZERO && link.addr[LOCK_RESET_BIT]) begin
          lockQ <= LOCK_WAIT;
        end
      end
      if (issued && link.cmd == CMD_LONG_CAL) begin
        calQ <= CAL_WAIT;
        calRun_q <= 1'b1;
      end else if (lockQ != '0 || calQ != '0) begin
        lockQ <= (lockQ != '0) ? lockQ - 1'b1 : lockQ;
        calQ <= (calQ != '0) ? calQ - 1'b1 : calQ;
      end else if (calRun_q) begin
        ready_q <= 1'b1;
      end
    end
  end

  // Refresh counter survives the pin reset on purpose.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      refreshCount <= '0;
    end else if (issued && link.cmd == CMD_REFRESH) begin
      refreshCount <= refreshCount + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      link.devReady <= 1'b0;
    end else begin
      link.devReady <= ready_q;
    end
  end

endmodule
`default_nettype wire

//--- dv/sdram_init_mode_program_seq_checker.sv
// Checker for the init link: reset pulse, command spacing, order and readiness.
// Assumes the bench instantiates it beside the link, on the same clock and reset.
`timescale 1ns/100ps
`default_nettype none
module sdram_init_mode_program_seq_checker
  import dram_init_pkg::*;
#(
  parameter int RESET_PULSE = int'(DEF_RESET_PULSE),
  parameter int MODE_SET_WAIT = int'(DEF_MODE_SET),
  parameter int MODE_UPDATE_WAIT = int'(DEF_MODE_UPDATE),
  parameter int READY_WAIT = int'((DEF_LOCK > DEF_CAL) ? DEF_LOCK : DEF_CAL),
  parameter int IDLE_LIMIT = int'(DEF_IDLE_LIMIT)
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic resetPinN,
  input wire logic clkEnable,
  input wire logic chipSelN,
  input wire cmd_t cmd,
  input wire logic [SEL_W-1:0] regSel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic devReady
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  localparam logic [SEL_W-1:0] NEXT_SEL [8] = '{3'h3, 3'h0, 3'h1, 3'h6, 3'h2, 3'h4, 3'h5, 3'h7};
  logic [15:0] sinceSet_q, sinceCal_q, lowCnt_q, idleCnt_q;
  logic [SEL_W-1:0] lastSel_q;
  wire anySet = !chipSelN && cmd == CMD_MODE_SET;
  wire isCal = !chipSelN && cmd == CMD_LONG_CAL;
  sequence zeroSet;
    anySet && regSel == SEL_ZERO;
  endsequence
  sequence calCmd;
    isCal;
  endsequence

  // Reset holds the pulse count as met, so a pin released straight after reset is not flagged.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sinceSet_q <= 16'h00FF;
      sinceCal_q <= 16'h0000;
      lowCnt_q <= 16'(RESET_PULSE);
      idleCnt_q <= 16'h0000;
      lastSel_q <= SEL_ZERO;
    end else begin
      sinceSet_q <= anySet ? 16'h0001 : sinceSet_q + 16'h0001;
      sinceCal_q <= isCal ? 16'h0001 : sinceCal_q + 16'h0001;
      lowCnt_q <= resetPinN ? 16'h0000 : lowCnt_q + 16'h0001;
      idleCnt_q <= (!devReady || !chipSelN) ? 16'h0000 : idleCnt_q + 16'h0001;
      if (anySet) lastSel_q <= regSel;
    end
  end

  a_pulse_width: assert property ($rose(resetPinN) |-> lowCnt_q >= RESET_PULSE && !clkEnable)
    else $error("reset pin pulse short or clock enable high");
  // A system reset drops clock enable on purpose, so the cycle after it is not judged.
  a_cke_held: assert property ($fell(clkEnable) && $past(resetn) |-> $past(devReady))
    else $error("clock enable dropped during init");
  a_set_spacing: assert property (anySet |-> sinceSet_q >= MODE_SET_WAIT)
    else $error("set commands too close");
  a_set_order: assert property (anySet |-> regSel == NEXT_SEL[lastSel_q])
    else $error("set command out of order");
  a_update_delay: assert property (!chipSelN && !anySet |-> sinceSet_q >= MODE_UPDATE_WAIT)
    else $error("command before update delay");
  a_cal_after_zero: assert property (zeroSet |-> ##[1:60] calCmd)
    else $error("no calibration after register zero");
  a_ready_after_cal: assert property ($rose(devReady) |-> sinceCal_q >= READY_WAIT)
    else $error("device ready too early");
  a_keep_alive: assert property (devReady |-> idleCnt_q <= IDLE_LIMIT + 8)
    else $error("idle too long without refresh");
endmodule
`default_nettype wire

//--- dv/sdram_init_mode_program_seq_tb_top.sv
// Bench top: both ends joined by the link, random mode values, warm and supply restarts.
// Assumes the core package, link interface and both ends are compiled first.
`timescale 1ns/100ps
`default_nettype none
module sdram_init_mode_program_seq_tb_top;
  import dram_init_pkg::*;
  logic sys_clk, resetn, startReq, supplyChanged, initDone, keepAlive, spacingErr;
  logic [ADDR_W-1:0] modeValue [MODE_REGS];
  logic [ADDR_W-1:0] modeReg [MODE_REGS];
  logic [15:0] refreshCount, refreshSeen;
  logic [31:0] rnd;
  int n_fail, n_checks, nSets, nKeep, seed;
  // Only the post-reset wait and the idle limit are shortened to keep the run brief; the
  // spacing, lock and calibration counts run at their defaults so both ends agree on them.
  localparam logic [CNT_W-1:0] POST_CYC = 32'h0000_0032;
  localparam logic [CNT_W-1:0] IDLE_CYC = 32'h0000_0064;
  localparam int IDLE_SPAN = 250;
  dram_init_if link();
  dram_init_ctrl #(.POST_RESET(POST_CYC), .IDLE_LIMIT(IDLE_CYC)) dram_init_ctrl_i (.sys_clk,
    .resetn, .startReq, .supplyChanged, .modeValue, .initDone, .keepAlive, .link(link.ctrl));
  dram_init_dev dram_init_dev_i (.sys_clk, .resetn, .link(link.dev), .modeReg, .refreshCount,
    .spacingErr);
  sdram_init_mode_program_seq_checker #(.IDLE_LIMIT(int'(IDLE_CYC))) checker_i (.sys_clk,
    .resetn, .resetPinN(link.resetPinN),
    .clkEnable(link.clkEnable), .chipSelN(link.chipSelN), .cmd(link.cmd), .regSel(link.regSel),
    .addr(link.addr), .devReady(link.devReady));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Register expected for the n-th set command of one init pass; zero always comes last.
  function automatic logic [2:0] expectSel(input int n);
    case (n % MODE_REGS)
      0: expectSel = SEL_THREE;
      1: expectSel = SEL_SIX;
      2: expectSel = SEL_FIVE;
      3: expectSel = SEL_FOUR;
      4: expectSel = SEL_TWO;
      5: expectSel = SEL_ONE;
      default: expectSel = SEL_ZERO;
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d fails=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One-cycle start request; a supply change takes the same full restart path.
  task automatic kick(input bit supply);
    @(posedge sys_clk);
    startReq <= !supply;
    supplyChanged <= supply;
    @(posedge sys_clk);
    startReq <= 1'b0;
    supplyChanged <= 1'b0;
  endtask

  // Every set command must carry the full value of its register, in the fixed order.
  always @(posedge sys_clk) begin
    if (resetn && !link.chipSelN && link.cmd == CMD_MODE_SET) begin
      check(32'(link.regSel), 32'(expectSel(nSets)));
      check(32'(link.addr), 32'(modeValue[link.regSel]));
      nSets++;
    end
    if (keepAlive === 1'b1) nKeep++;
  end

  // Run 1 sends a start mid-sequence that must be ignored; run 3 is cut by a reset.
  initial begin
    seed = 32'h99FE1FB0;
    n_fail = 0;
    n_checks = 0;
    resetn = 1'b0;
    startReq = 1'b0;
    supplyChanged = 1'b0;
    foreach (modeValue[k]) modeValue[k] = '0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int run = 0; run < 4; run++) begin
      @(posedge sys_clk);
      foreach (modeValue[k]) begin
        rnd = $random(seed);
        modeValue[k] <= rnd[ADDR_W-1:0] | (18'h1 << ((k == 0) ? LOCK_RESET_BIT : LOCK_ENABLE_BIT));
      end
      nSets = 0;
      refreshSeen = refreshCount;
      kick(run == 2);
      repeat (130) @(posedge sys_clk); // Lands after the third set command.
      startReq <= (run == 1);
      resetn <= (run != 3);
      @(posedge sys_clk);
      startReq <= 1'b0;
      resetn <= 1'b1;
      if (run == 3) begin
        @(posedge sys_clk);
        check(32'(link.devReady), 32'h0);
        nSets = 0;
        refreshSeen = refreshCount;
        kick(1'b0);
      end
      for (int i = 0; i < 3000 && initDone !== 1'b1; i++) @(posedge sys_clk);
      check(32'(initDone), 32'h1);
      check(32'(link.devReady), 32'h1);
      check(32'(nSets), 32'h7);
      check(32'(spacingErr), 32'h0);
      check(32'(refreshCount), 32'(refreshSeen));
      foreach (modeReg[k]) check(32'(modeReg[k]), 32'(modeValue[k]));
      nKeep = 0;
      repeat (IDLE_SPAN) @(posedge sys_clk);
      check(32'(nKeep), 32'(IDLE_SPAN / IDLE_CYC));
      check(32'(refreshCount - refreshSeen), 32'(nKeep));
    end
    complete_run();
  end

  // Four full inits of about 1200 cycles and one cut short, with idle spans, need under 8000 cycles.
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
